// *** hdl/rss_top.v ***
// Ramp segment sequencer with APB register file
//
// What this block does
// (RQ1) Half-rate segments tick every two clocks, others every clock.
// (RQ2) A segment ticks for its length count; zero means 65536.
// (RQ3) Segment start drives both marker bits from the 2-bit marker field.
// (RQ4) Accumulator clear option zeroes the accumulator as the segment begins.
// (RQ5) Advance code 0 is length timeout, 1..3 are events A, B, C.
// (RQ6) On advance, continue at the segment named by the successor index.
// (RQ7) Timeout segments start the successor right away.
// (RQ8) Trigger segments hand over only when the chosen event arrives.
// (RQ9) Each tick adds the signed step value to the numerator.
// (RQ10) Numerator advances over a fixed 2^24 denominator while ramping.
// (RQ11) Outside party feeds shift trigger on an input-configured pad.
// (RQ12) While ramping is enabled and shift trigger is active, deviation adds onto the carrier.
// (RQ13) Pad drive code 7 makes the pad an input usable as trigger.
// (RQ14) Source 1 is pad one rising edge, 3 is modulation pad rising.
// (RQ15) Upper and lower limits are 33-bit two's complement values.
// (RQ16) Source code 2 in advance field routes event B.
// (RQ17) With ramping enabled, a divider low byte write starts segment 0.
// (RQ18) Accumulator is clamped at the lower and upper limits before deviation is added.
// (RQ19) Segment change loads all segment settings before the first tick.
`timescale 1ns/10ps
`default_nettype none
`include "rss_map.vh"
module rss_top #(
    parameter SEGS = 8,
    parameter INC_W = 30
) (
    input wire sys_clk,
    input wire arst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire external_event_pad_one,
    input wire external_event_pad_two,
    input wire mod_pad,
    output reg marker_bit_zero,
    output reg marker_bit_one,
    output reg [32:0] ramp_numerator_q,
    output reg [7:0] ndiv_low_q,
    output reg ramping_q
);
    // ****************************************************************
    // Configuration state
    // ****************************************************************
    reg ramp_en_q;
    reg [3:0] event_a_source, event_b_source, event_c_source;
    reg [1:0] shift_trigger_select;
    reg [2:0] pad_one_drive, pad_two_drive, mod_drive;
    reg [32:0] shift_deviation_value;
    reg [32:0] limit_low_q;
    reg [32:0] limit_high_q;
    reg [INC_W-1:0] seg_step_mem [0:SEGS-1];
    reg [`RSS_CFG_W-1:0] seg_cfg_mem [0:SEGS-1];
    // ****************************************************************
    // Sequencer state
    // ****************************************************************
    localparam ST_IDLE = 2'd0;
    localparam ST_LOAD = 2'd1;
    localparam ST_RUN = 2'd2;
    localparam ST_WAIT = 2'd3;
    reg [1:0] state_q;
    reg [2:0] seg_idx_q;
    reg [INC_W-1:0] segment_step_value;
    reg [16:0] tick_left_q;
    reg segment_half_rate;
    reg [1:0] segment_advance_condition;
    reg [2:0] segment_successor_index;
    reg [32:0] accum_q;
    reg limit_hit_q;
    reg mark0_prev_q;
    wire tick;
    // ****************************************************************
    // Pads, only usable as triggers when set as inputs
    // ****************************************************************
    wire p1_lvl, p1_rise, p1_fall;
    wire p2_lvl, p2_rise, p2_fall;
    wire md_lvl, md_rise, md_fall;
    rss_sync u_sync_one (
        .sys_clk(sys_clk), .arst_n(arst_n), .pad_in(external_event_pad_one),
        .level_q(p1_lvl), .rise_q(p1_rise), .fall_q(p1_fall)
    );
    rss_sync u_sync_two (
        .sys_clk(sys_clk), .arst_n(arst_n), .pad_in(external_event_pad_two),
        .level_q(p2_lvl), .rise_q(p2_rise), .fall_q(p2_fall)
    );
    rss_sync u_sync_mod (
        .sys_clk(sys_clk), .arst_n(arst_n), .pad_in(mod_pad),
        .level_q(md_lvl), .rise_q(md_rise), .fall_q(md_fall)
    );
    wire in1 = (pad_one_drive == `RSS_PAD_INPUT); // [RQ13]
    wire in2 = (pad_two_drive == `RSS_PAD_INPUT); // [RQ13]
    wire inm = (mod_drive == `RSS_PAD_INPUT); // [RQ13]
    wire m0_rise = marker_bit_zero & ~mark0_prev_q;
    wire m0_fall = ~marker_bit_zero & mark0_prev_q;
    // Lock detect, comparator and fastlock sources live elsewhere: never fire
    wire [15:0] edge_vec = {m0_fall, 3'b000, inm & md_fall, in2 & p2_fall,
        in1 & p1_fall, 1'b1, m0_rise, 3'b000, inm & md_rise, in2 & p2_rise,
        in1 & p1_rise, 1'b0}; // [RQ14]
    wire [15:0] lvl_vec = {~marker_bit_zero, 3'b000, inm & ~md_lvl,
        in2 & ~p2_lvl, in1 & ~p1_lvl, 1'b1, marker_bit_zero, 3'b000,
        inm & md_lvl, in2 & p2_lvl, in1 & p1_lvl, 1'b0};
    function pick;
        input [3:0] src;
        input [15:0] vec;
        begin
            pick = vec[src];
        end
    endfunction
    wire ev_a = pick(event_a_source, edge_vec);
    wire ev_b = pick(event_b_source, edge_vec);
    wire ev_c = pick(event_c_source, edge_vec);
    reg adv_event;
    always @* begin
        case (segment_advance_condition) // [RQ5]
            2'd1: adv_event = ev_a;
            2'd2: adv_event = ev_b; // [RQ16]
            2'd3: adv_event = ev_c;
            default: adv_event = 1'b0;
        endcase
    end
    // Shift follows the trigger level so the deviation holds while active
    reg shift_on;
    always @* begin
        case (shift_trigger_select)
            2'd1: shift_on = pick(event_a_source, lvl_vec);
            2'd2: shift_on = pick(event_b_source, lvl_vec);
            2'd3: shift_on = pick(event_c_source, lvl_vec);
            default: shift_on = 1'b1;
        endcase
    end
    // ****************************************************************
    // APB slave, zero wait states
    // ****************************************************************
    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pready & pwrite;
    wire seg_hit = (paddr >= `RSS_SEG_BASE_OFS) && (paddr <= `RSS_SEG_END_OFS);
    wire [2:0] seg_sel = paddr[5:3];
    wire ndiv_wr = wr_en && (paddr == `RSS_NDIV_LO_OFS);
    reg [31:0] rd_d;
    reg map_ok;
    always @* begin
        rd_d = 32'h00000000;
        map_ok = 1'b1;
        if (paddr[1:0] != 2'b00) begin
            map_ok = 1'b0;
        end else if (seg_hit) begin
            if (paddr[2]) begin
                rd_d = {{(32-`RSS_CFG_W){1'b0}}, seg_cfg_mem[seg_sel]};
            end else begin
                rd_d = {{(32-INC_W){1'b0}}, seg_step_mem[seg_sel]};
            end
        end else begin
            case (paddr)
                `RSS_CTRL_OFS: rd_d = {31'h00000000, ramp_en_q};
                `RSS_NDIV_LO_OFS: rd_d = {24'h000000, ndiv_low_q};
                `RSS_EVENT_SRC_OFS: rd_d = {20'h00000, event_c_source,
                    event_b_source, event_a_source};
                `RSS_SHIFT_SEL_OFS: rd_d = {30'h00000000, shift_trigger_select};
                `RSS_PAD_DRIVE_OFS: rd_d = {23'h000000, mod_drive,
                    pad_two_drive, pad_one_drive};
                `RSS_SHIFT_DEV_OFS: rd_d = shift_deviation_value[31:0];
                `RSS_LIMIT_LOW_OFS: rd_d = limit_low_q[31:0];
                `RSS_LIMIT_HIGH_OFS: rd_d = limit_high_q[31:0];
                `RSS_MSB_OFS: rd_d = {28'h0000000, accum_q[32],
                    limit_high_q[32], limit_low_q[32], shift_deviation_value[32]};
                `RSS_STATUS_OFS: rd_d = {26'h0000000, limit_hit_q,
                    state_q, seg_idx_q};
                `RSS_ACCUM_OFS: rd_d = accum_q[31:0];
                default: map_ok = 1'b0;
            endcase
        end
    end
    integer i;
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ramp_en_q <= 1'b0;
            ndiv_low_q <= 8'h00;
            event_a_source <= 4'h0;
            event_b_source <= 4'h0;
            event_c_source <= 4'h0;
            shift_trigger_select <= 2'h0;
            pad_one_drive <= 3'h0;
            pad_two_drive <= 3'h0;
            mod_drive <= 3'h0;
            shift_deviation_value <= 33'h000000000;
            limit_low_q <= `RSS_LIMIT_LOW_RST;
            limit_high_q <= `RSS_LIMIT_HIGH_RST;
            for (i = 0; i < SEGS; i = i + 1) begin
                seg_step_mem[i] <= {INC_W{1'b0}};
                seg_cfg_mem[i] <= {`RSS_CFG_W{1'b0}};
            end
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : rd_d;
                pslverr <= ~map_ok;
            end
            if (wr_en && map_ok) begin
                if (seg_hit) begin
                    if (paddr[2]) begin
                        seg_cfg_mem[seg_sel] <= pwdata[`RSS_CFG_W-1:0];
                    end else begin
                        seg_step_mem[seg_sel] <= pwdata[INC_W-1:0];
                    end
                end else begin
                    case (paddr)
                        `RSS_CTRL_OFS: ramp_en_q <= pwdata[0];
                        `RSS_NDIV_LO_OFS: ndiv_low_q <= pwdata[7:0];
                        `RSS_EVENT_SRC_OFS: begin
                            event_a_source <= pwdata[3:0];
                            event_b_source <= pwdata[7:4];
                            event_c_source <= pwdata[11:8];
                        end
                        `RSS_SHIFT_SEL_OFS: shift_trigger_select <= pwdata[1:0];
                        `RSS_PAD_DRIVE_OFS: begin
                            pad_one_drive <= pwdata[2:0];
                            pad_two_drive <= pwdata[5:3];
                            mod_drive <= pwdata[8:6];
                        end
                        `RSS_SHIFT_DEV_OFS: shift_deviation_value[31:0] <= pwdata;
                        `RSS_LIMIT_LOW_OFS: limit_low_q[31:0] <= pwdata; // [RQ15]
                        `RSS_LIMIT_HIGH_OFS: limit_high_q[31:0] <= pwdata; // [RQ15]
                        `RSS_MSB_OFS: begin
                            shift_deviation_value[32] <= pwdata[0];
                            limit_low_q[32] <= pwdata[1]; // [RQ15]
                            limit_high_q[32] <= pwdata[2]; // [RQ15]
                        end
                        default: ;
                    endcase
                end
            end
        end
    end
    // ****************************************************************
    // Tick source
    // ****************************************************************
    rss_tick u_tick (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .run(state_q == ST_RUN),
        .half_rate(segment_half_rate),
        .tick_q(tick)
    );
    // ****************************************************************
    // Accumulator step with limits, before deviation
    // ****************************************************************
    wire [33:0] step_ext = {{(34-INC_W){segment_step_value[INC_W-1]}},
        segment_step_value};
    wire [33:0] sum = {accum_q[32], accum_q} + step_ext; // [RQ9]
    wire [33:0] lo_ext = {limit_low_q[32], limit_low_q};
    wire [33:0] hi_ext = {limit_high_q[32], limit_high_q};
    wire below = $signed(sum) < $signed(lo_ext);
    wire above = $signed(sum) > $signed(hi_ext);
    wire [32:0] next_acc = below ? limit_low_q :
        (above ? limit_high_q : sum[32:0]); // [RQ18]
    wire [`RSS_CFG_W-1:0] ld_cfg = seg_cfg_mem[seg_idx_q];
    wire [15:0] ld_len = ld_cfg[`RSS_CFG_LEN_MSB:`RSS_CFG_LEN_LSB];
    // ****************************************************************
    // Segment sequencer
    // ****************************************************************
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            seg_idx_q <= 3'h0;
            segment_step_value <= {INC_W{1'b0}};
            tick_left_q <= 17'h00000;
            segment_half_rate <= 1'b0;
            segment_advance_condition <= 2'h0;
            segment_successor_index <= 3'h0;
            accum_q <= 33'h000000000;
            limit_hit_q <= 1'b0;
            marker_bit_zero <= 1'b0;
            marker_bit_one <= 1'b0;
            mark0_prev_q <= 1'b0;
        end else begin
            mark0_prev_q <= marker_bit_zero;
            if (!ramp_en_q) begin
                state_q <= ST_IDLE;
            end else if (ndiv_wr) begin
                seg_idx_q <= 3'h0; // [RQ17]
                state_q <= ST_LOAD; // [RQ17]
            end else begin
                case (state_q)
                    ST_LOAD: begin
                        segment_step_value <= seg_step_mem[seg_idx_q]; // [RQ19]
                        segment_half_rate <= ld_cfg[`RSS_CFG_HALF]; // [RQ19]
                        segment_advance_condition <=
                            ld_cfg[`RSS_CFG_ADV_MSB:`RSS_CFG_ADV_LSB];
                        segment_successor_index <=
                            ld_cfg[`RSS_CFG_NEXT_MSB:`RSS_CFG_NEXT_LSB];
                        // Zero length stands for the full count
                        tick_left_q <= (ld_len == 16'h0000) ? `RSS_FULL_LEN :
                            {1'b0, ld_len}; // [RQ2]
                        marker_bit_zero <= ld_cfg[`RSS_CFG_MARK_LSB]; // [RQ3]
                        marker_bit_one <= ld_cfg[`RSS_CFG_MARK_MSB]; // [RQ3]
                        if (ld_cfg[`RSS_CFG_CLR]) begin
                            accum_q <= 33'h000000000; // [RQ4]
                        end
                        state_q <= ST_RUN;
                    end
                    ST_RUN: begin
                        if (tick) begin
                            accum_q <= next_acc; // [RQ10]
                            limit_hit_q <= below | above;
                            tick_left_q <= tick_left_q - 17'h00001; // [RQ2]
                        end
                        if (segment_advance_condition != `RSS_ADV_TIMEOUT) begin
                            if (adv_event) begin
                                seg_idx_q <= segment_successor_index; // [RQ8]
                                state_q <= ST_LOAD;
                            end else if (tick && tick_left_q == 17'h00001) begin
                                state_q <= ST_WAIT;
                            end
                        end else if (tick && tick_left_q == 17'h00001) begin
                            seg_idx_q <= segment_successor_index; // [RQ6]
                            state_q <= ST_LOAD; // [RQ7]
                        end
                    end
                    ST_WAIT: begin
                        // Holds the reached value until the chosen event
                        if (adv_event) begin
                            seg_idx_q <= segment_successor_index; // [RQ8]
                            state_q <= ST_LOAD;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end
    // ****************************************************************
    // Output numerator: limited accumulator plus deviation
    // ****************************************************************
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ramp_numerator_q <= 33'h000000000;
            ramping_q <= 1'b0;
        end else begin
            ramping_q <= (state_q != ST_IDLE);
            if (ramp_en_q && shift_on) begin
                ramp_numerator_q <= accum_q + shift_deviation_value; // [RQ12]
            end else begin
                ramp_numerator_q <= accum_q;
            end
        end
    end
endmodule
`default_nettype wire

// *** hdl/rss_map.vh ***
// Register offsets, field positions and reset values of the ramp segment sequencer
`ifndef RSS_MAP_VH
`define RSS_MAP_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RSS_CTRL_OFS 12'h000
`define RSS_NDIV_LO_OFS 12'h004
`define RSS_EVENT_SRC_OFS 12'h008
`define RSS_SHIFT_SEL_OFS 12'h00C
`define RSS_PAD_DRIVE_OFS 12'h010
`define RSS_SHIFT_DEV_OFS 12'h014
`define RSS_LIMIT_LOW_OFS 12'h018
`define RSS_LIMIT_HIGH_OFS 12'h01C
`define RSS_MSB_OFS 12'h020
`define RSS_STATUS_OFS 12'h024
`define RSS_ACCUM_OFS 12'h028
`define RSS_SEG_BASE_OFS 12'h040
`define RSS_SEG_END_OFS 12'h07F
// ****************************************************************
// Segment configuration word fields
// ****************************************************************
`define RSS_CFG_LEN_LSB 0
`define RSS_CFG_LEN_MSB 15
`define RSS_CFG_HALF 16
`define RSS_CFG_MARK_LSB 17
`define RSS_CFG_MARK_MSB 18
`define RSS_CFG_CLR 19
`define RSS_CFG_ADV_LSB 20
`define RSS_CFG_ADV_MSB 21
`define RSS_CFG_NEXT_LSB 22
`define RSS_CFG_NEXT_MSB 24
`define RSS_CFG_W 25
// ****************************************************************
// Codes and reset values
// ****************************************************************
`define RSS_PAD_INPUT 3'h7
`define RSS_ADV_TIMEOUT 2'h0
`define RSS_LIMIT_HIGH_RST 33'h0FFFFFFFF
`define RSS_LIMIT_LOW_RST 33'h000000000
`define RSS_FULL_LEN 17'h10000
`endif

// *** hdl/rss_sync.v ***
// Three-stage pad synchroniser with qualified level and edge pulses
`timescale 1ns/10ps
`default_nettype none
module rss_sync (
    input wire sys_clk,
    input wire arst_n,
    input wire pad_in,
    output reg level_q,
    output reg rise_q,
    output reg fall_q
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    // Level only moves once the second and third stages agree
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            s1_q <= pad_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            rise_q <= (s2_q == s3_q) && s2_q && !level_q;
            fall_q <= (s2_q == s3_q) && !s2_q && level_q;
            if (s2_q == s3_q) begin
                level_q <= s2_q;
            end
        end
    end
endmodule
`default_nettype wire

// *** hdl/rss_tick.v ***
// Ramp tick enable: every clock, or every second clock at half rate
`timescale 1ns/10ps
`default_nettype none
module rss_tick (
    input wire sys_clk,
    input wire arst_n,
    input wire run,
    input wire half_rate,
    output reg tick_q
);
    reg phase_q;
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_q <= 1'b0;
            tick_q <= 1'b0;
        end else if (!run) begin
            phase_q <= 1'b0;
            tick_q <= 1'b0;
        end else if (half_rate) begin
            phase_q <= ~phase_q;
            tick_q <= phase_q; // [RQ1]
        end else begin
            tick_q <= 1'b1; // [RQ1]
        end
    end
endmodule
`default_nettype wire

// *** verification/rss_pads.sv ***
// Trigger pad stimulus model standing in for the outside event sources
`timescale 1ns/10ps
`default_nettype none
module rss_pads (
    input wire logic sys_clk,
    output logic pad_one,
    output logic pad_two,
    output logic pad_mod
);
    initial begin
        pad_one = 1'b0;
        pad_two = 1'b0;
        pad_mod = 1'b0;
    end
    // Rising edge held for hold clocks; long holds mimic a slow source
    task automatic pulse(input int idx, input int hold);
        @(posedge sys_clk);
        case (idx)
            0: pad_one <= 1'b1;
            1: pad_two <= 1'b1;
            default: pad_mod <= 1'b1;
        endcase
        repeat (hold) @(posedge sys_clk);
        pad_one <= 1'b0;
        pad_two <= 1'b0;
        pad_mod <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verification/rss_top_assertions.sv ***
// Port checker for the ramp segment sequencer
`timescale 1ns/10ps
`default_nettype none
module rss_top_assertions #(
    parameter SEGS = 8,
    parameter INC_W = 30
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [32:0] ramp_numerator_q,
    input wire logic [7:0] ndiv_low_q,
    input wire logic ramping_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic en_q;
    wire wr = psel && penable && pwrite && pready;
    // Shadow of the enable bit, since the checker cannot see registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) en_q <= 1'b0;
        else if (wr && paddr == 12'h000) en_q <= pwdata[0];
    end
    chk_zero_wait: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    chk_misalign_err: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access not refused");
    chk_err_no_data: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    chk_ndiv_capture: assert property (
        wr && paddr == 12'h004 |=> ndiv_low_q == $past(pwdata[7:0]))
        else $error("divider byte not captured");
    chk_ndiv_hold: assert property (!(wr && paddr == 12'h004) |=> $stable(ndiv_low_q))
        else $error("divider byte changed without write");
    chk_ramp_start: assert property (
        wr && paddr == 12'h004 && en_q |-> ##[1:3] ramping_q)
        else $error("ramp did not start");
    chk_ramp_stop: assert property (
        wr && paddr == 12'h000 && !pwdata[0] |-> ##[1:3] !ramping_q)
        else $error("ramp did not stop");
    chk_idle_hold: assert property (
        !en_q && !$past(en_q) && !$past(en_q, 2) |-> $stable(ramp_numerator_q))
        else $error("numerator moved while disabled");
    cover property (wr && paddr == 12'h004 && en_q);
    cover property (psel && penable && pslverr);
    cover property ($fell(ramping_q));
endmodule
bind rss_top rss_top_assertions #(.SEGS(SEGS), .INC_W(INC_W)) u_chk (
    .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ramp_numerator_q(ramp_numerator_q), .ndiv_low_q(ndiv_low_q), .ramping_q(ramping_q));
`default_nettype wire

// *** verification/test_ramp_segment_sequencer.sv ***
// Self-checking bench for the ramp segment sequencer
`timescale 1ns/10ps
`default_nettype none
module test_ramp_segment_sequencer;
    logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, p1, p2, pm, m0, m1, run;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [32:0] num;
    logic [7:0] ndiv;
    logic err;
    int n_fail, n_checks;
    rss_top i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_event_pad_one(p1), .external_event_pad_two(p2),
        .mod_pad(pm), .marker_bit_zero(m0), .marker_bit_one(m1), .ramp_numerator_q(num),
        .ndiv_low_q(ndiv), .ramping_q(run));
    rss_pads i_pads (.sys_clk(sys_clk), .pad_one(p1), .pad_two(p2), .pad_mod(pm));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Setup, access, then hold until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic seg(input logic [2:0] i, input logic [31:0] step, input logic [15:0] len,
        input logic half, input logic [1:0] mk, input logic clr, input logic [1:0] adv,
        input logic [2:0] nx);
        apb(1'b1, 12'h040 + {6'h0, i, 3'h0}, step);
        apb(1'b1, 12'h044 + {6'h0, i, 3'h0}, {7'h0, nx, adv, clr, mk, half, len});
    endtask
    task automatic t_regs;
        apb(1'b0, 12'h01C, 32'h0);
        check("limit_high", rd, 33'h0FFFFFFFF);
        apb(1'b0, 12'h020, 32'h0);
        check("msb_bits", rd, 33'h0);
        apb(1'b0, 12'h030, 32'h0);
        check("unmapped_err", err, 33'h1);
        check("unmapped_data", rd, 33'h0);
        apb(1'b1, 12'h002, 32'h1);
        check("unaligned_err", err, 33'h1);
        $display("t_regs done");
    endtask
    task automatic t_timeout;
        seg(3'h0, 32'h3, 16'h0004, 1'b0, 2'h3, 1'b0, 2'h0, 3'h1);
        seg(3'h1, 32'h3FFFFFF0, 16'h0001, 1'b0, 2'h2, 1'b0, 2'h1, 3'h2);
        seg(3'h2, 32'h0, 16'h0001, 1'b0, 2'h1, 1'b1, 2'h2, 3'h3);
        seg(3'h3, 32'h7, 16'h0008, 1'b1, 2'h3, 1'b0, 2'h0, 3'h1);
        apb(1'b1, 12'h008, 32'h031);
        apb(1'b1, 12'h018, 32'hFFFFFFFE);
        apb(1'b1, 12'h020, 32'h2);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b1, 12'h004, 32'h60);
        repeat (30) @(posedge sys_clk);
        check("numerator", num, 33'h1FFFFFFFE);
        check("markers", {m1, m0}, 33'h2);
        check("ndiv", ndiv, 33'h60);
        apb(1'b0, 12'h024, 32'h0);
        check("segment", rd[2:0], 33'h1);
        check("limit_hit", rd[5], 33'h1);
        $display("t_timeout done");
    endtask
    task automatic t_trigger;
        i_pads.pulse(0, 6);
        repeat (12) @(posedge sys_clk);
        apb(1'b0, 12'h024, 32'h0);
        check("pad_ignored", rd[2:0], 33'h1);
        apb(1'b1, 12'h010, 32'h1C7);
        i_pads.pulse(0, 6);
        repeat (12) @(posedge sys_clk);
        check("cleared", num, 33'h0);
        check("markers", {m1, m0}, 33'h1);
        apb(1'b0, 12'h024, 32'h0);
        check("segment", rd[2:0], 33'h2);
        $display("t_trigger done");
    endtask
    task automatic t_half_rate;
        int n;
        int k;
        i_pads.pulse(2, 2);
        n = 0;
        do begin
            apb(1'b0, 12'h024, 32'h0);
            n++;
        end while (rd[2:0] != 3'h3 && n < 20);
        k = 0;
        while (rd[2:0] == 3'h3 && k < 60) begin
            apb(1'b0, 12'h024, 32'h0);
            k += 3;
        end
        check("half_rate", k >= 14 && n < 20, 33'h1);
        repeat (5) @(posedge sys_clk);
        check("numerator", num, 33'h28);
        check("markers", {m1, m0}, 33'h2);
        $display("t_half_rate done");
    endtask
    task automatic t_shift;
        apb(1'b1, 12'h014, 32'h64);
        repeat (4) @(posedge sys_clk);
        check("shifted", num, 33'h8C);
        apb(1'b1, 12'h000, 32'h0);
        repeat (4) @(posedge sys_clk);
        check("unshifted", num, 33'h28);
        check("ramping", run, 33'h0);
        $display("t_shift done");
    endtask
    initial begin
        n_fail = 0;
        n_checks = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        arst_n = 1'b0;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_timeout();
        t_trigger();
        t_half_rate();
        t_shift();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        end_sim();
    end
endmodule
`default_nettype wire
